// ---- core/mel_cmd_decode.sv ----
// Card-side decoder for erase, lock, protect report and app commands.
// Assumes link clock and command pin asynchronous, APB on clk_i.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module mel_cmd_decode #(
  parameter int WP_GRP_SHIFT = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic link_clk_i,
  input wire logic cmd_i,
  output logic dat0_o,
  output logic dat0_oe_o,
  output logic rsp_req_o,
  output logic [5:0] rsp_index_o,
  output logic rsp_busy_o,
  output logic xfer_req_o,
  output mel_pkg::mel_xfer_t xfer_kind_o,
  output logic xfer_to_host_o,
  output logic [11:0] xfer_len_o,
  output logic bus_4bit_o
);
  import mel_pkg::*;

  // ==========================================================
  // Pin synchronisers and link clock edges
  logic lclk;
  logic cmd_s;
  logic lclk_q;
  logic lrise;
  logic lfall;

  mel_sync #(.W(2), .RST_VAL(2'b01)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_i({link_clk_i, cmd_i}),
    .out_o({lclk, cmd_s})
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lclk_q <= 1'b0;
    end else begin
      lclk_q <= lclk;
    end
  end
  assign lrise = lclk & ~lclk_q;
  assign lfall = ~lclk & lclk_q;

  // ==========================================================
  // Registers
  mel_state_t state_reg;
  logic [47:0] sr_reg;
  logic [5:0] cnt_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] block_len_reg;
  logic [31:0] wp_map_reg;
  logic [31:0] wp_limit_reg;
  logic [31:0] erase_first_reg;
  logic [31:0] erase_last_reg;
  logic [31:0] block_count_reg;
  logic [31:0] payload_reg;
  mel_erase_t erase_kind_reg;
  logic app_pending_reg;
  logic illegal_reg;
  logic [5:0] last_idx_reg;
  logic capacity_status_flag;
  logic locked;

  assign capacity_status_flag = ctrl_reg[CTRL_CCS_BIT];
  assign locked = ctrl_reg[CTRL_LOCKED_BIT];

  // ==========================================================
  // Frame fields and decode
  logic [5:0] idx;
  logic [31:0] arg;
  logic [31:0] blk_addr;
  logic [31:0] grp;
  logic frame_ok;
  logic exec;
  logic legal;
  logic illegal;
  logic busy;
  logic to_host;
  logic [11:0] len;
  mel_xfer_t kind;
  logic [31:0] wp_bits;

  assign idx = sr_reg[45:40];
  assign arg = sr_reg[39:8];
  assign frame_ok = ~sr_reg[47] & sr_reg[46] & sr_reg[0];
  assign exec = (state_reg == ST_EXEC) && frame_ok;
  assign blk_addr = capacity_status_flag ? arg : (arg >> BYTE_ADDR_SHIFT);
  assign grp = blk_addr >> WP_GRP_SHIFT;

  always_comb begin
    legal = 1'b0;
    illegal = 1'b0;
    busy = 1'b0;
    to_host = 1'b1;
    kind = XFER_NONE;
    len = block_len_reg[11:0];
    if (app_pending_reg && idx == ACMD_BUS_WIDTH) begin
      legal = ~arg[0];
      illegal = arg[0];
    end else if (app_pending_reg && idx == ACMD_EXT_STATUS) begin
      legal = 1'b1;
      kind = XFER_EXT_STATUS;
      len = EXT_STATUS_BYTES;
    end else if (app_pending_reg && idx <= ACMD_RES_MAX) begin
      illegal = 1'b1;
    end else begin
      case (idx)
        CMD_BLOCK_LEN, CMD_BLOCK_COUNT: legal = 1'b1;
        CMD_APP: legal = (arg[31:16] == ctrl_reg[31:16]);
        CMD_WP_REPORT: begin
          legal = ctrl_reg[CTRL_WP_EN_BIT] & ~capacity_status_flag & ~locked;
          illegal = ~legal;
          kind = XFER_WP;
        end
        CMD_ERASE_FIRST, CMD_ERASE_LAST: begin
          legal = ~locked;
          illegal = locked;
        end
        CMD_ERASE: begin
          legal = ~locked;
          illegal = locked;
          busy = 1'b1;
        end
        CMD_LOCKED_READ: begin
          legal = 1'b1;
          kind = XFER_LOCKED_READ;
        end
        CMD_LOCK: begin
          legal = 1'b1;
          kind = XFER_LOCK;
          to_host = 1'b0;
          len = block_len_reg[11:0];
        end
        CMD_GENERAL: begin
          legal = ~locked;
          illegal = locked;
          kind = XFER_GENERAL;
          to_host = arg[0];
          len = capacity_status_flag ? HC_BLOCK_BYTES : block_len_reg[11:0];
        end
        CMD_RES_A, CMD_RES_B, CMD_RES_C: illegal = 1'b1;
        default: illegal = (idx >= CMD_MFR_FIRST);
      endcase
    end
  end

  // Protect bits, group g+i in bit i
  for (genvar i = 0; i < 32; i++) begin : g_wp
    logic [31:0] gi;
    assign gi = grp + 32'(i);
    assign wp_bits[i] = (gi < wp_limit_reg) && (gi < 32'h0000_0020)
                        && wp_map_reg[gi[4:0]];
  end

  // ==========================================================
  // Link state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      sr_reg <= 48'h0000_0000_0000;
      cnt_reg <= 6'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (lrise && !cmd_s) begin
            state_reg <= ST_RX;
            sr_reg <= 48'h0000_0000_0000;
            cnt_reg <= 6'h01;
          end
        end
        ST_RX: begin
          if (lrise) begin
            sr_reg <= {sr_reg[46:0], cmd_s};
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == FRAME_BITS - 6'h01) begin
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          cnt_reg <= 6'h00;
          state_reg <= (exec && legal && kind == XFER_WP) ? ST_TX
                                                         : ST_IDLE;
        end
        ST_TX: begin
          if (lfall) begin
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == TX_LAST) begin
              state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Protect report payload on the data line
  logic [15:0] crc;
  logic crc_en;
  logic [5:0] dsel;
  logic [5:0] csel;

  assign dsel = WP_BITS - cnt_reg;
  assign csel = FRAME_BITS - cnt_reg;
  assign crc_en = (state_reg == ST_TX) && lfall && cnt_reg != 6'h00
                  && cnt_reg <= WP_BITS;

  mel_crc16 u_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(state_reg == ST_EXEC),
    .en_i(crc_en),
    .bit_i(payload_reg[dsel[4:0]]),
    .crc_o(crc)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      payload_reg <= 32'h0000_0000;
      dat0_o <= 1'b1;
      dat0_oe_o <= 1'b0;
    end else begin
      if (exec && legal && kind == XFER_WP) begin
        payload_reg <= wp_bits;
      end
      if (state_reg == ST_TX && lfall) begin
        dat0_oe_o <= (cnt_reg != TX_LAST);
        if (cnt_reg == 6'h00) begin
          dat0_o <= 1'b0;
        end else if (cnt_reg <= WP_BITS) begin
          dat0_o <= payload_reg[dsel[4:0]];
        end else if (cnt_reg < TX_LAST) begin
          dat0_o <= crc[csel[3:0]];
        end else begin
          dat0_o <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Command effects
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_first_reg <= 32'h0000_0000;
      erase_last_reg <= 32'h0000_0000;
      erase_kind_reg <= ERASE_PLAIN;
      block_count_reg <= 32'h0000_0000;
      bus_4bit_o <= 1'b0;
      app_pending_reg <= 1'b0;
      last_idx_reg <= 6'h00;
    end else if (exec) begin
      app_pending_reg <= 1'b0;
      if (legal) begin
        last_idx_reg <= idx;
        if (app_pending_reg && idx == ACMD_BUS_WIDTH) begin
          bus_4bit_o <= arg[1];
        end else if (idx == CMD_APP) begin
          app_pending_reg <= 1'b1;
        end else if (idx == CMD_ERASE_FIRST) begin
          erase_first_reg <= blk_addr;
        end else if (idx == CMD_ERASE_LAST) begin
          erase_last_reg <= blk_addr;
        end else if (idx == CMD_BLOCK_COUNT) begin
          block_count_reg <= arg;
        end else if (idx == CMD_ERASE) begin
          if (arg == ERASE_FN_DISCARD) begin
            erase_kind_reg <= ERASE_DISCARD;
          end else if (arg == ERASE_FN_FULL) begin
            erase_kind_reg <= ERASE_FULL_USER;
          end else begin
            erase_kind_reg <= ERASE_PLAIN;
          end
        end
      end
    end
  end

  // Response and transfer requests
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_req_o <= 1'b0;
      rsp_index_o <= 6'h00;
      rsp_busy_o <= 1'b0;
      xfer_req_o <= 1'b0;
      xfer_kind_o <= XFER_NONE;
      xfer_to_host_o <= 1'b0;
      xfer_len_o <= 12'h000;
    end else begin
      rsp_req_o <= exec && legal;
      xfer_req_o <= exec && legal && kind != XFER_NONE
                    && kind != XFER_WP;
      if (exec && legal) begin
        rsp_index_o <= idx;
        rsp_busy_o <= busy;
        xfer_kind_o <= kind;
        xfer_to_host_o <= to_host;
        xfer_len_o <= len;
      end
    end
  end

  // ==========================================================
  // APB slave
  logic wr;
  logic mapped;
  logic [31:0] rd;

  assign wr = psel_i && penable_i && pwrite_i && mapped;
  assign pready_o = psel_i && penable_i;

  always_comb begin
    mapped = 1'b1;
    rd = 32'h0000_0000;
    case (paddr_i)
      REG_CTRL: rd = ctrl_reg;
      REG_BLOCK_LEN: rd = block_len_reg;
      REG_WP_MAP: rd = wp_map_reg;
      REG_WP_LIMIT: rd = wp_limit_reg;
      REG_ERASE_FIRST: rd = erase_first_reg;
      REG_ERASE_LAST: rd = erase_last_reg;
      REG_STATUS: rd = {20'h0_0000, last_idx_reg, app_pending_reg,
                        illegal_reg, bus_4bit_o, 1'b0, erase_kind_reg};
      REG_BLOCK_COUNT: rd = block_count_reg;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_o <= rd;
      pslverr_o <= !mapped;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      block_len_reg <= BLOCK_LEN_RST;
      wp_map_reg <= 32'h0000_0000;
      wp_limit_reg <= WP_LIMIT_RST;
    end else begin
      if (exec && legal && !app_pending_reg && idx == CMD_BLOCK_LEN) begin
        block_len_reg <= arg;
      end
      if (wr) begin
        case (paddr_i)
          REG_CTRL: ctrl_reg <= pwdata_i;
          REG_BLOCK_LEN: block_len_reg <= pwdata_i;
          REG_WP_MAP: wp_map_reg <= pwdata_i;
          REG_WP_LIMIT: wp_limit_reg <= pwdata_i;
          default: ;
        endcase
      end
    end
  end

  // Illegal flag: set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      illegal_reg <= 1'b0;
    end else if (exec && illegal) begin
      illegal_reg <= 1'b1;
    end else if (wr && paddr_i == REG_STATUS
                 && pwdata_i[STAT_ILLEGAL_BIT]) begin
      illegal_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tx_end;
    (state_reg == ST_TX) && lfall && (cnt_reg == TX_LAST);
  endsequence

  AST_WP_FRAME: assert property (
    s_tx_end |=> !dat0_oe_o && (state_reg == ST_IDLE))
    else $error("protect report not 50 bits");
  AST_WP_LSB_LAST: assert property (
    (state_reg == ST_TX) && lfall && (cnt_reg == WP_BITS)
    |=> dat0_o == payload_reg[0])
    else $error("first group bit not last");
  AST_WP_RANGE: assert property (
    exec && legal && kind == XFER_WP
    && (grp + 32'h0000_001F >= wp_limit_reg)
    |=> !payload_reg[31])
    else $error("out of range group not zero");
  AST_ERASE_FIRST: assert property (
    exec && legal && !app_pending_reg && idx == CMD_ERASE_FIRST
    |=> erase_first_reg == $past(blk_addr) && rsp_req_o)
    else $error("erase start not latched");
  AST_ERASE_LAST: assert property (
    exec && legal && !app_pending_reg && idx == CMD_ERASE_LAST
    |=> erase_last_reg == $past(blk_addr))
    else $error("erase end not latched");
  AST_ERASE_KIND: assert property (
    exec && legal && idx == CMD_ERASE && arg == ERASE_FN_DISCARD
    |=> erase_kind_reg == ERASE_DISCARD && rsp_busy_o)
    else $error("discard not selected");
  AST_LOCKED_READ: assert property (
    exec && !app_pending_reg && idx == CMD_LOCKED_READ |-> legal)
    else $error("locked read refused");
  AST_LOCK_LEN: assert property (
    xfer_req_o && xfer_kind_o == XFER_LOCK
    |-> xfer_len_o == block_len_reg[11:0])
    else $error("lock block length wrong");
  AST_APP_NEXT: assert property (
    exec && legal && !app_pending_reg && idx == CMD_APP
    |=> app_pending_reg ##1 (!exec)[*1])
    else $error("prefix not remembered");
  AST_GEN_LEN: assert property (
    xfer_req_o && xfer_kind_o == XFER_GENERAL && capacity_status_flag
    |-> xfer_len_o == HC_BLOCK_BYTES)
    else $error("general block not 512");
  AST_BUS_WIDTH: assert property (
    exec && app_pending_reg && idx == ACMD_BUS_WIDTH && arg[1:0] == 2'b10
    |=> bus_4bit_o)
    else $error("four lines not selected");
  AST_RESERVED: assert property (
    exec && !app_pending_reg && idx == CMD_RES_A
    |=> illegal_reg && !rsp_req_o && $stable(erase_first_reg))
    else $error("reserved command accepted");

endmodule : mel_cmd_decode

// ---- core/mel_crc16.sv ----
// Serial CRC-16 (x^16 + x^12 + x^5 + 1) for the data line payload.
// Assumes one data bit per enable, cleared before each block.
`timescale 1ns/1ps
module mel_crc16 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic en_i,
  input wire logic bit_i,
  output logic [15:0] crc_o
);
  logic fb;

  assign fb = crc_o[15] ^ bit_i;

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      crc_o <= 16'h0000;
    end else if (en_i) begin
      crc_o <= {crc_o[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
  end
endmodule : mel_crc16

// ---- core/mel_pkg.sv ----
// Shared constants and types of the card command decoder.
// Assumes a single 200 MHz clock domain for every user of it.
package mel_pkg;

  // ==========================================================
  // Command indices
  localparam logic [5:0] CMD_BLOCK_LEN = 6'h10;
  localparam logic [5:0] CMD_BLOCK_COUNT = 6'h17;
  localparam logic [5:0] CMD_WP_REPORT = 6'h1E;
  localparam logic [5:0] CMD_RES_A = 6'h1F;
  localparam logic [5:0] CMD_ERASE_FIRST = 6'h20;
  localparam logic [5:0] CMD_ERASE_LAST = 6'h21;
  localparam logic [5:0] CMD_ERASE = 6'h26;
  localparam logic [5:0] CMD_LOCKED_READ = 6'h28;
  localparam logic [5:0] CMD_RES_B = 6'h29;
  localparam logic [5:0] CMD_LOCK = 6'h2A;
  localparam logic [5:0] CMD_RES_C = 6'h33;
  localparam logic [5:0] CMD_APP = 6'h37;
  localparam logic [5:0] CMD_GENERAL = 6'h38;
  localparam logic [5:0] CMD_MFR_FIRST = 6'h3C;
  localparam logic [5:0] ACMD_BUS_WIDTH = 6'h06;
  localparam logic [5:0] ACMD_EXT_STATUS = 6'h0D;
  localparam logic [5:0] ACMD_RES_MAX = 6'h15;

  // ==========================================================
  // Argument codes and sizes
  localparam logic [31:0] ERASE_FN_DISCARD = 32'h0000_0001;
  localparam logic [31:0] ERASE_FN_FULL = 32'h0000_0002;
  localparam logic [5:0] FRAME_BITS = 6'h30;
  localparam logic [5:0] WP_BITS = 6'h20;
  localparam logic [5:0] TX_LAST = 6'h31;
  localparam int BYTE_ADDR_SHIFT = 9;
  localparam logic [11:0] HC_BLOCK_BYTES = 12'h200;
  localparam logic [11:0] EXT_STATUS_BYTES = 12'h040;

  // ==========================================================
  // Register map (byte offsets) and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BLOCK_LEN = 8'h04;
  localparam logic [7:0] REG_WP_MAP = 8'h08;
  localparam logic [7:0] REG_WP_LIMIT = 8'h0C;
  localparam logic [7:0] REG_ERASE_FIRST = 8'h10;
  localparam logic [7:0] REG_ERASE_LAST = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_BLOCK_COUNT = 8'h1C;
  localparam int CTRL_CCS_BIT = 0;
  localparam int CTRL_LOCKED_BIT = 1;
  localparam int CTRL_WP_EN_BIT = 2;
  localparam int STAT_ILLEGAL_BIT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BLOCK_LEN_RST = 32'h0000_0200;
  localparam logic [31:0] WP_LIMIT_RST = 32'h0000_0020;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RX = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_TX = 4'b1000
  } mel_state_t;

  typedef enum logic [1:0] {
    ERASE_PLAIN = 2'b00,
    ERASE_DISCARD = 2'b01,
    ERASE_FULL_USER = 2'b10
  } mel_erase_t;

  typedef enum logic [2:0] {
    XFER_NONE = 3'h0,
    XFER_WP = 3'h1,
    XFER_LOCK = 3'h2,
    XFER_GENERAL = 3'h3,
    XFER_EXT_STATUS = 3'h4,
    XFER_LOCKED_READ = 3'h5
  } mel_xfer_t;

endpackage : mel_pkg

// ---- core/mel_sync.sv ----
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
module mel_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] in_i,
  output logic [W-1:0] out_o
);
  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff1_reg <= RST_VAL;
      ff2_reg <= RST_VAL;
      ff3_reg <= RST_VAL;
      out_o <= RST_VAL;
    end else begin
      ff1_reg <= in_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      for (int i = 0; i < W; i++) begin
        if (ff2_reg[i] == ff3_reg[i]) begin
          out_o[i] <= ff3_reg[i];
        end
      end
    end
  end
endmodule : mel_sync

// ---- verif/mel_host_model.sv ----
// Host side model: clocks the link, drives commands, samples the data line.
// Assumes the card samples on rising and drives on falling link edges.
`timescale 1ns/1ps
module mel_host_model (
  output logic link_clk_o,
  output logic cmd_o,
  input wire logic dat0_i,
  input wire logic dat0_oe_i
);
  logic [63:0] rx_reg;
  int rx_cnt;
  logic dat0_line;
  // Pulled up while the card is not driving
  assign dat0_line = dat0_oe_i ? dat0_i : 1'b1;
  initial begin
    link_clk_o = 1'b0;
    cmd_o = 1'b1;
    rx_reg = '0;
    rx_cnt = 0;
  end
  // ==========================================================
  // One link cycle, clock still between frames
  // Sample late in the high phase: card output lags by up to 25 ns
  task automatic tick();
    #24 link_clk_o = 1'b1;
    #24;
    if (dat0_oe_i === 1'b1) begin
      rx_reg = {rx_reg[62:0], dat0_line};
      rx_cnt++;
    end
    link_clk_o = 1'b0;
  endtask : tick
  // Frame sent first bit first, check bits left zero
  task automatic send(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] f;
    f = {2'b01, idx, arg, 7'h00, 1'b1};
    for (int i = 47; i >= 0; i--) begin
      cmd_o = f[i];
      tick();
    end
    cmd_o = 1'b1;
  endtask : send
  task automatic run(input int n);
    rx_cnt = 0;
    repeat (n) tick();
  endtask : run
endmodule : mel_host_model

// ---- verif/tb_top.sv ----
// Self-checking bench: APB register access plus host command traffic.
// Assumes the host model in its own file and the design package.
`timescale 1ns/1ps
module tb_top;
  import mel_pkg::*;
  logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, exp_wp;
  logic link_clk_i, cmd_i, dat0_o, dat0_oe_o, rsp_req_o, rsp_busy_o;
  logic xfer_req_o, xfer_to_host_o, bus_4bit_o, err;
  logic [5:0] rsp_index_o;
  logic [11:0] xfer_len_o;
  mel_xfer_t xfer_kind_o;
  int failures, tests_run, n_rsp, n_xfer;
  logic [31:0] fn [3] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0007};
  logic [1:0] ek [3] = '{2'b01, 2'b10, 2'b00};
  mel_cmd_decode mel_cmd_decode_inst (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .link_clk_i(link_clk_i),
    .cmd_i(cmd_i), .dat0_o(dat0_o), .dat0_oe_o(dat0_oe_o),
    .rsp_req_o(rsp_req_o), .rsp_index_o(rsp_index_o),
    .rsp_busy_o(rsp_busy_o), .xfer_req_o(xfer_req_o),
    .xfer_kind_o(xfer_kind_o), .xfer_to_host_o(xfer_to_host_o),
    .xfer_len_o(xfer_len_o), .bus_4bit_o(bus_4bit_o));
  mel_host_model mel_host_model_inst (.link_clk_o(link_clk_i),
    .cmd_o(cmd_i), .dat0_i(dat0_o), .dat0_oe_i(dat0_oe_o));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (rsp_req_o === 1'b1) n_rsp++;
    if (xfer_req_o === 1'b1) n_xfer++;
  end
  // ==========================================================
  // Tasks
  task automatic summarize();
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc
  task automatic cmd(input logic [5:0] i, input logic [31:0] arg,
                     input int er, input int ex);
    int r0;
    int x0;
    r0 = n_rsp;
    x0 = n_xfer;
    mel_host_model_inst.send(i, arg);
    repeat (20) @(posedge clk_i);
    chk(n_rsp - r0, er);
    chk(n_xfer - x0, ex);
  endtask : cmd
  task automatic acmd(input logic [5:0] i, input logic [31:0] arg,
                      input int er, input int ex);
    cmd(CMD_APP, 32'h1234_FFFF, 1, 0);
    cmd(i, arg, er, ex);
  endtask : acmd
  function automatic logic [15:0] crc16(input logic [31:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 31; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc16
  initial begin
    watchdog();
  end
  task automatic watchdog();
    #400_000;
    failures++;
    summarize();
  endtask : watchdog
  // ==========================================================
  // Main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    failures = 0;
    tests_run = 0;
    n_rsp = 0;
    n_xfer = 0;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdc(REG_BLOCK_LEN, BLOCK_LEN_RST);
    rdc(REG_WP_LIMIT, WP_LIMIT_RST);
    rdc(REG_CTRL, CTRL_RST);
    rdc(8'h20, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, REG_CTRL, 32'h1234_0004);
    cmd(CMD_ERASE_FIRST, 32'h0000_0400, 1, 0);
    rdc(REG_ERASE_FIRST, 32'h0000_0002);
    chk(32'(rsp_index_o), 32'(CMD_ERASE_FIRST));
    cmd(CMD_ERASE_LAST, 32'h0000_0A00, 1, 0);
    rdc(REG_ERASE_LAST, 32'h0000_0005);
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_ERASE, fn[i], 1, 0);
      chk(32'(rsp_busy_o), 32'h0000_0001);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      chk(32'(rd[1:0]), 32'(ek[i]));
    end
    apb(1'b1, REG_CTRL, 32'h1234_0005);
    cmd(CMD_ERASE_FIRST, 32'h0000_0007, 1, 0);
    rdc(REG_ERASE_FIRST, 32'h0000_0007);
    cmd(CMD_BLOCK_COUNT, 32'h0000_0009, 1, 0);
    rdc(REG_BLOCK_COUNT, 32'h0000_0009);
    cmd(CMD_BLOCK_LEN, 32'h0000_0040, 1, 0);
    cmd(CMD_LOCK, 32'h0000_0000, 1, 1);
    chk(32'(xfer_kind_o), 32'(XFER_LOCK));
    chk(32'(xfer_len_o), 32'h0000_0040);
    cmd(CMD_GENERAL, 32'h0000_0001, 1, 1);
    chk(32'(xfer_to_host_o), 32'h0000_0001);
    chk(32'(xfer_len_o), 32'(HC_BLOCK_BYTES));
    apb(1'b1, REG_CTRL, 32'h1234_0004);
    cmd(CMD_GENERAL, 32'h0000_0000, 1, 1);
    chk(32'(xfer_to_host_o), 32'h0000_0000);
    chk(32'(xfer_len_o), 32'h0000_0040);
    acmd(ACMD_BUS_WIDTH, 32'h0000_0002, 1, 0);
    chk(32'(bus_4bit_o), 32'h0000_0001);
    acmd(ACMD_BUS_WIDTH, 32'h0000_0000, 1, 0);
    chk(32'(bus_4bit_o), 32'h0000_0000);
    cmd(ACMD_BUS_WIDTH, 32'h0000_0002, 0, 0);
    cmd(CMD_APP, 32'h4321_0000, 0, 0);
    cmd(ACMD_BUS_WIDTH, 32'h0000_0002, 0, 0);
    chk(32'(bus_4bit_o), 32'h0000_0000);
    acmd(ACMD_EXT_STATUS, 32'h0000_0000, 1, 1);
    chk(32'(xfer_kind_o), 32'(XFER_EXT_STATUS));
    chk(32'(xfer_len_o), 32'(EXT_STATUS_BYTES));
    chk(32'(xfer_to_host_o), 32'h0000_0001);
    acmd(6'h11, 32'h0000_0000, 0, 0);
    cmd(CMD_RES_B, 32'h0000_0000, 0, 0);
    cmd(CMD_RES_A, 32'h0000_0000, 0, 0);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(32'(rd[STAT_ILLEGAL_BIT]), 32'h0000_0001);
    apb(1'b1, REG_STATUS, 32'h0000_0010);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(32'(rd[STAT_ILLEGAL_BIT]), 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h1234_0006);
    cmd(CMD_LOCKED_READ, 32'h0000_0000, 1, 1);
    chk(32'(xfer_kind_o), 32'(XFER_LOCKED_READ));
    cmd(CMD_ERASE_FIRST, 32'h0000_2000, 0, 0);
    rdc(REG_ERASE_FIRST, 32'h0000_0007);
    apb(1'b1, REG_CTRL, 32'h1234_0004);
    apb(1'b1, REG_WP_MAP, 32'hF0F0_00A5);
    apb(1'b1, REG_WP_LIMIT, 32'h0000_0014);
    exp_wp = (32'hF0F0_00A5 >> 2) & 32'h0003_FFFF;
    cmd(CMD_WP_REPORT, 32'h0000_4000, 1, 0);
    mel_host_model_inst.run(60);
    chk(32'(mel_host_model_inst.rx_cnt), 32'h0000_0031);
    chk(mel_host_model_inst.rx_reg[47:16], exp_wp);
    chk(32'(mel_host_model_inst.rx_reg[15:0]), 32'(crc16(exp_wp)));
    chk(32'(mel_host_model_inst.rx_reg[48]), 32'h0000_0000);
    summarize();
  end
endmodule : tb_top
